/* File: jsp_consts.svh */
/*
  Constants of the test-access and emulation pin block: instruction codes,
  register lengths, reset values and synchroniser bit positions.
  Assumes inclusion by bare name from the design files.
*/
`ifndef JSP_CONSTS_SVH
`define JSP_CONSTS_SVH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define JSP_IR_LEN      4
`define JSP_IR_BYPASS   4'hF
`define JSP_IR_IDCODE   4'h1
`define JSP_IR_EMU_CTRL 4'h2
`define JSP_IR_CAPTURE  4'h1

// ----------------------------------------------------------------------
// data registers
// ----------------------------------------------------------------------
`define JSP_ID_LEN      32
`define JSP_CTL_LEN     2
`define JSP_CTL_RESET   2'h0
`define JSP_CTL_DIR_A   0
`define JSP_CTL_DIR_B   1

// ----------------------------------------------------------------------
// synchronised pin positions
// ----------------------------------------------------------------------
`define JSP_SYNC_W      6
`define JSP_PIN_TCK     0
`define JSP_PIN_TMS     1
`define JSP_PIN_TDI     2
`define JSP_PIN_TRST    3
`define JSP_PIN_EVA     4
`define JSP_PIN_EVB     5

`endif

/* File: jsp_pkg.sv */
/*
  Types of the test-access and emulation pin block.
  Assumes nothing of its surroundings.
*/
package jsp_pkg;

  // ----------------------------------------------------------------------
  // test access port states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [15:0] {
    TAP_RESET      = 16'h0001,
    TAP_IDLE       = 16'h0002,
    TAP_SEL_DR     = 16'h0004,
    TAP_CAPTURE_DR = 16'h0008,
    TAP_SHIFT_DR   = 16'h0010,
    TAP_EXIT1_DR   = 16'h0020,
    TAP_PAUSE_DR   = 16'h0040,
    TAP_EXIT2_DR   = 16'h0080,
    TAP_UPDATE_DR  = 16'h0100,
    TAP_SEL_IR     = 16'h0200,
    TAP_CAPTURE_IR = 16'h0400,
    TAP_SHIFT_IR   = 16'h0800,
    TAP_EXIT1_IR   = 16'h1000,
    TAP_PAUSE_IR   = 16'h2000,
    TAP_EXIT2_IR   = 16'h4000,
    TAP_UPDATE_IR  = 16'h8000
  } jsp_tap_state_t;

endpackage : jsp_pkg

/* File: jsp_sync.sv */
/*
  Two-flop synchroniser for a bundle of independent pin levels.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/100ps

module jsp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage is read by the second stage only
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : jsp_sync

/* File: jsp_tap.sv */
/*
  Test access port with emulator event pins, device side. Samples the test
  clock, mode select, data input and test reset on the system clock and
  runs the port state machine on detected test clock edges.
  Assumes the test clock is at most an eighth of clock_in and that
  boundary-scan cells and the emulator interrupt logic sit outside.
*/
// Behaviour
// - test reset high gives scan control; low ignores
// - mode select sampled on test clock rise
// - data input shifted in on test clock rise
// - data output changes on test clock fall
// - event pins high/low, test reset rise: boundary-scan
// - event pins are emulator interrupts, direction scanned
`timescale 1ns/100ps
`include "jsp_consts.svh"

module jsp_tap #(
  parameter logic [31:0] ID_VALUE = 32'h1234_5671  // arbitrary value
) (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic reset_in,
  // test access pins
  input  wire logic test_reset_in,
  input  wire logic tck_in,
  input  wire logic tms_in,
  input  wire logic tdi_in,
  output logic      tdo_out,
  output logic      tdo_oe_out,
  // debug event pins
  input  wire logic debug_event_pin_a_in,
  output logic      debug_event_pin_a_out,
  output logic      debug_event_pin_a_oe_out,
  input  wire logic debug_event_pin_b_in,
  output logic      debug_event_pin_b_out,
  output logic      debug_event_pin_b_oe_out,
  // core side
  input  wire logic emu_event_a_in,
  input  wire logic emu_event_b_in,
  output logic      emu_event_a_out,
  output logic      emu_event_b_out,
  output logic      scan_control_out,
  output logic      boundary_scan_mode_out
);

  // ----------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [`JSP_SYNC_W-1:0] pins_s;
  logic tck_s, tms_s, tdi_s, trst_s, ev_a_s, ev_b_s;
  logic tck_d_q, trst_d_q;
  logic tck_rise, tck_fall, trst_rise;

  jsp_sync #(.WIDTH(`JSP_SYNC_W)) u_sync (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in ({debug_event_pin_b_in, debug_event_pin_a_in, test_reset_in,
                tdi_in, tms_in, tck_in}),
    .sync_out (pins_s)
  );

  assign tck_s  = pins_s[`JSP_PIN_TCK];
  assign tms_s  = pins_s[`JSP_PIN_TMS];
  assign tdi_s  = pins_s[`JSP_PIN_TDI];
  assign trst_s = pins_s[`JSP_PIN_TRST];
  assign ev_a_s = pins_s[`JSP_PIN_EVA];
  assign ev_b_s = pins_s[`JSP_PIN_EVB];

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      tck_d_q  <= 1'b0;
      trst_d_q <= 1'b0;
    end else begin
      tck_d_q  <= tck_s;
      trst_d_q <= trst_s;
    end
  end

  assign tck_rise  = tck_s & ~tck_d_q;
  assign tck_fall  = ~tck_s & tck_d_q;
  assign trst_rise = trst_s & ~trst_d_q;

  // ----------------------------------------------------------------------
  // port state machine
  // ----------------------------------------------------------------------
  jsp_pkg::jsp_tap_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      jsp_pkg::TAP_RESET:      state_d = tms_s ? jsp_pkg::TAP_RESET : jsp_pkg::TAP_IDLE;
      jsp_pkg::TAP_IDLE:       state_d = tms_s ? jsp_pkg::TAP_SEL_DR : jsp_pkg::TAP_IDLE;
      jsp_pkg::TAP_SEL_DR:     state_d = tms_s ? jsp_pkg::TAP_SEL_IR : jsp_pkg::TAP_CAPTURE_DR;
      jsp_pkg::TAP_CAPTURE_DR: state_d = tms_s ? jsp_pkg::TAP_EXIT1_DR : jsp_pkg::TAP_SHIFT_DR;
      jsp_pkg::TAP_SHIFT_DR:   state_d = tms_s ? jsp_pkg::TAP_EXIT1_DR : jsp_pkg::TAP_SHIFT_DR;
      jsp_pkg::TAP_EXIT1_DR:   state_d = tms_s ? jsp_pkg::TAP_UPDATE_DR : jsp_pkg::TAP_PAUSE_DR;
      jsp_pkg::TAP_PAUSE_DR:   state_d = tms_s ? jsp_pkg::TAP_EXIT2_DR : jsp_pkg::TAP_PAUSE_DR;
      jsp_pkg::TAP_EXIT2_DR:   state_d = tms_s ? jsp_pkg::TAP_UPDATE_DR : jsp_pkg::TAP_SHIFT_DR;
      jsp_pkg::TAP_UPDATE_DR:  state_d = tms_s ? jsp_pkg::TAP_SEL_DR : jsp_pkg::TAP_IDLE;
      jsp_pkg::TAP_SEL_IR:     state_d = tms_s ? jsp_pkg::TAP_RESET : jsp_pkg::TAP_CAPTURE_IR;
      jsp_pkg::TAP_CAPTURE_IR: state_d = tms_s ? jsp_pkg::TAP_EXIT1_IR : jsp_pkg::TAP_SHIFT_IR;
      jsp_pkg::TAP_SHIFT_IR:   state_d = tms_s ? jsp_pkg::TAP_EXIT1_IR : jsp_pkg::TAP_SHIFT_IR;
      jsp_pkg::TAP_EXIT1_IR:   state_d = tms_s ? jsp_pkg::TAP_UPDATE_IR : jsp_pkg::TAP_PAUSE_IR;
      jsp_pkg::TAP_PAUSE_IR:   state_d = tms_s ? jsp_pkg::TAP_EXIT2_IR : jsp_pkg::TAP_PAUSE_IR;
      jsp_pkg::TAP_EXIT2_IR:   state_d = tms_s ? jsp_pkg::TAP_UPDATE_IR : jsp_pkg::TAP_SHIFT_IR;
      jsp_pkg::TAP_UPDATE_IR:  state_d = tms_s ? jsp_pkg::TAP_SEL_DR : jsp_pkg::TAP_IDLE;
      default:                 state_d = jsp_pkg::TAP_RESET;
    endcase
  end

  // test reset low holds the port in reset and ignores the test clock
  always_ff @(posedge clock_in) begin
    if (reset_in || !trst_s) begin
      state_q <= jsp_pkg::TAP_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      scan_control_out <= 1'b0;
    end else begin
      scan_control_out <= trst_s;
    end
  end

  // ----------------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------------
  logic [`JSP_IR_LEN-1:0] ir_sr_q;
  logic [`JSP_IR_LEN-1:0] ir_q;

  always_ff @(posedge clock_in) begin
    if (reset_in || !trst_s) begin
      ir_sr_q <= `JSP_IR_CAPTURE;
      ir_q    <= `JSP_IR_IDCODE;
    end else if (tck_rise) begin
      case (state_q)
        jsp_pkg::TAP_RESET:      ir_q    <= `JSP_IR_IDCODE;
        jsp_pkg::TAP_CAPTURE_IR: ir_sr_q <= `JSP_IR_CAPTURE;
        jsp_pkg::TAP_SHIFT_IR:   ir_sr_q <= {tdi_s, ir_sr_q[`JSP_IR_LEN-1:1]};
        jsp_pkg::TAP_UPDATE_IR:  ir_q    <= ir_sr_q;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // data registers: bypass, identity, emulator pin direction
  // ----------------------------------------------------------------------
  logic                    bypass_q;
  logic [`JSP_ID_LEN-1:0]  id_sr_q;
  logic [`JSP_CTL_LEN-1:0] ctl_sr_q;
  logic [`JSP_CTL_LEN-1:0] ctl_q;
  logic                    dr_lsb;

  always_ff @(posedge clock_in) begin
    if (reset_in || !trst_s) begin
      bypass_q <= 1'b0;
      id_sr_q  <= '0;
      ctl_sr_q <= `JSP_CTL_RESET;
    end else if (tck_rise) begin
      if (state_q == jsp_pkg::TAP_CAPTURE_DR) begin
        bypass_q <= 1'b0;
        id_sr_q  <= ID_VALUE;
        ctl_sr_q <= ctl_q;
      end else if (state_q == jsp_pkg::TAP_SHIFT_DR) begin
        if (ir_q == `JSP_IR_IDCODE) begin
          id_sr_q <= {tdi_s, id_sr_q[`JSP_ID_LEN-1:1]};
        end else if (ir_q == `JSP_IR_EMU_CTRL) begin
          ctl_sr_q <= {tdi_s, ctl_sr_q[`JSP_CTL_LEN-1:1]};
        end else begin
          bypass_q <= tdi_s;
        end
      end
    end
  end

  // direction holds through functional mode but clears on the first test clock rise in the reset state
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctl_q <= `JSP_CTL_RESET;
    end else if (trst_s && tck_rise) begin
      if (state_q == jsp_pkg::TAP_RESET) begin
        ctl_q <= `JSP_CTL_RESET;
      end else if (state_q == jsp_pkg::TAP_UPDATE_DR && ir_q == `JSP_IR_EMU_CTRL) begin
        ctl_q <= ctl_sr_q;
      end
    end
  end

  always_comb begin
    if (ir_q == `JSP_IR_IDCODE) begin
      dr_lsb = id_sr_q[0];
    end else if (ir_q == `JSP_IR_EMU_CTRL) begin
      dr_lsb = ctl_sr_q[0];
    end else begin
      dr_lsb = bypass_q;
    end
  end

  // ----------------------------------------------------------------------
  // data output, updated on the falling test clock edge
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in || !trst_s) begin
      tdo_out    <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_out    <= (state_q == jsp_pkg::TAP_SHIFT_IR) ? ir_sr_q[0] : dr_lsb;
      tdo_oe_out <= (state_q == jsp_pkg::TAP_SHIFT_IR) ||
                    (state_q == jsp_pkg::TAP_SHIFT_DR);
    end
  end

  // ----------------------------------------------------------------------
  // boundary-scan entry and emulator event pins
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in || !trst_s) begin
      boundary_scan_mode_out <= 1'b0;
    end else if (trst_rise && ev_a_s && !ev_b_s) begin
      boundary_scan_mode_out <= 1'b1;
    end
  end

  // pins are only used for events while under scan control
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      debug_event_pin_a_out    <= 1'b0;
      debug_event_pin_b_out    <= 1'b0;
      debug_event_pin_a_oe_out <= 1'b0;
      debug_event_pin_b_oe_out <= 1'b0;
      emu_event_a_out          <= 1'b0;
      emu_event_b_out          <= 1'b0;
    end else begin
      debug_event_pin_a_out    <= emu_event_a_in;
      debug_event_pin_b_out    <= emu_event_b_in;
      debug_event_pin_a_oe_out <= trst_s & ctl_q[`JSP_CTL_DIR_A];
      debug_event_pin_b_oe_out <= trst_s & ctl_q[`JSP_CTL_DIR_B];
      emu_event_a_out <= trst_s & ~ctl_q[`JSP_CTL_DIR_A] & ev_a_s;
      emu_event_b_out <= trst_s & ~ctl_q[`JSP_CTL_DIR_B] & ev_b_s;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  func_mode_a: assert property (!trst_s |=> state_q == jsp_pkg::TAP_RESET)
    else $error("port left reset while test reset low");

  scan_ctl_a: assert property (trst_s ##1 trst_s |-> scan_control_out)
    else $error("scan control not given under test reset");

  tms_step_a: assert property (tck_rise && trst_s && state_q == jsp_pkg::TAP_RESET
                               && !tms_s |=> state_q == jsp_pkg::TAP_IDLE)
    else $error("mode select not taken on test clock rise");

  tdi_shift_a: assert property (tck_rise && trst_s && state_q == jsp_pkg::TAP_SHIFT_IR
                                |=> ir_sr_q[`JSP_IR_LEN-1] == $past(tdi_s))
    else $error("data input not shifted on test clock rise");

  tdo_fall_a: assert property ($changed(tdo_out) && $past(trst_s) |-> $past(tck_fall))
    else $error("data output changed off the falling edge");

  tdo_hiz_a: assert property (tck_fall && trst_s |=> tdo_oe_out ==
                              ($past(state_q) inside {jsp_pkg::TAP_SHIFT_IR,
                                                     jsp_pkg::TAP_SHIFT_DR}))
    else $error("data output enable wrong for state");

  bscan_latch_a: assert property (trst_rise && ev_a_s && !ev_b_s
                                  |=> boundary_scan_mode_out [*2])
    else $error("boundary-scan mode not latched");

  emu_dir_a: assert property (!trst_s |=> !debug_event_pin_a_oe_out
                              && !debug_event_pin_b_oe_out)
    else $error("event pin driven outside scan control");

endmodule : jsp_tap

/* File: jsp_tester.sv */
/*
  Model of the scan tester and emulator pod at the far side of the test pins.
  Assumes clock_in is the device system clock; the test clock runs at 80 ns
  only within frames and stands low between them.
*/
`timescale 1ns/100ps

module jsp_tester (
  // clock
  input  wire logic clock_in,
  // from the device
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in,
  // to the device
  output logic      test_reset_out,
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  // emulator event pins
  output logic      ev_a_out,
  output logic      ev_b_out,
  output logic      ev_oe_out
);
  logic tdo_seen;
  logic tdo_last_q = 1'b0;

  initial begin
    test_reset_out = 1'b0;
    tck_out        = 1'b0;
    tms_out        = 1'b0;
    tdi_out        = 1'b0;
    ev_a_out       = 1'b0;
    ev_b_out       = 1'b0;
    ev_oe_out      = 1'b0;
  end

  // a released data-out pin shows the inverse of its last value
  always @(posedge clock_in) begin
    if (tdo_oe_in) tdo_last_q <= tdo_in;
  end
  assign tdo_seen = tdo_oe_in ? tdo_in : ~tdo_last_q;

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wait_clk

  // one test clock period, 4 system clocks low then 4 high
  task automatic tck_bit(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    wait_clk(4);
    tck_out = 1'b1;
    wait_clk(4);
    tdo     = tdo_seen;
    tck_out = 1'b0;
  endtask : tck_bit

  // idle -> capture -> shift n bits lsb first -> update -> idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_ok);
    logic t;
    dout  = '0;
    oe_ok = 1'b1;
    tck_bit(1'b1, 1'b0, t);
    if (ir) tck_bit(1'b1, 1'b0, t);
    tck_bit(1'b0, 1'b0, t);
    tck_bit(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++) begin
      tck_bit(i == n - 1, din[i], t);
      dout[i] = t;
      oe_ok   = oe_ok & tdo_oe_in;
    end
    tck_bit(1'b1, 1'b0, t);
    tck_bit(1'b0, 1'b0, t);
  endtask : scan

  task automatic set_ev(input logic a, input logic b, input logic oe);
    ev_a_out  = a;
    ev_b_out  = b;
    ev_oe_out = oe;
  endtask : set_ev

  // event pins settle before the test reset rises
  task automatic enter(input logic a, input logic b);
    logic t;
    set_ev(a, b, 1'b1);
    wait_clk(4);
    test_reset_out = 1'b1;
    wait_clk(6);
    set_ev(a, b, 1'b0);
    tck_bit(1'b0, 1'b0, t);
  endtask : enter

  task automatic leave;
    test_reset_out = 1'b0;
    wait_clk(6);
  endtask : leave
endmodule : jsp_tester

/* File: tb.sv */
/*
  Self-checking bench of the test access and event pin block.
  Assumes the tester model drives the pins; event pins have a pull-up.
*/
`timescale 1ns/100ps
`include "jsp_consts.svh"

module tb;
  localparam logic [31:0] ID_VALUE = 32'h5A3C_96E1;  // arbitrary value

  logic   clock_in = 1'b0;
  logic   reset_in = 1'b1;
  logic   trst, tck, tms, tdi, tdo, tdo_oe, ev_a, ev_b, ev_oe;
  logic   dev_a, dev_a_oe, dev_b, dev_b_oe, emu_a_out, emu_b_out, scan_ctl, bs_mode;
  logic   emu_a_in = 1'b0;
  logic   emu_b_in = 1'b0;
  wire    pin_a = dev_a_oe ? dev_a : (ev_oe ? ev_a : 1'b1);
  wire    pin_b = dev_b_oe ? dev_b : (ev_oe ? ev_b : 1'b1);
  int     miscompares = 0;
  int     checks_done = 0;
  int     cycles = 0;
  integer seed = 32'h1131d943;

  always #5 clock_in = ~clock_in;

  jsp_tap #(.ID_VALUE(ID_VALUE)) dut (
    .clock_in(clock_in), .reset_in(reset_in), .test_reset_in(trst),
    .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
    .debug_event_pin_a_in(pin_a), .debug_event_pin_a_out(dev_a),
    .debug_event_pin_a_oe_out(dev_a_oe), .debug_event_pin_b_in(pin_b),
    .debug_event_pin_b_out(dev_b), .debug_event_pin_b_oe_out(dev_b_oe),
    .emu_event_a_in(emu_a_in), .emu_event_b_in(emu_b_in), .emu_event_a_out(emu_a_out),
    .emu_event_b_out(emu_b_out), .scan_control_out(scan_ctl),
    .boundary_scan_mode_out(bs_mode));

  jsp_tester tester (
    .clock_in(clock_in), .tdo_in(tdo), .tdo_oe_in(tdo_oe), .test_reset_out(trst),
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .ev_a_out(ev_a), .ev_b_out(ev_b),
    .ev_oe_out(ev_oe));

  // ----------------------------------------------------------------------
  // comparisons and verdict
  // ----------------------------------------------------------------------
  task automatic check_bit(input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected bit at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check_bit

  task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected word at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check_word

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // tests take about 1640 cycles; the ceiling leaves more than twice that
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] d, q;
    logic        ok, ea, eb;
    logic [3:0]  ir_code;
    logic [1:0]  ctl;
    tester.wait_clk(2);
    reset_in = 1'b0;
    tester.wait_clk(3);
    // clocking the port with test reset low must change nothing
    tester.scan(1'b0, 8, 32'hFF, q, ok);
    check_bit(1'b0, ok);
    check_bit(1'b0, scan_ctl);
    check_bit(1'b0, bs_mode);
    $display("test functional mode done");
    for (int k = 0; k < 4; k++) begin
      tester.enter(k[0], k[1]);
      check_bit(k == 1, bs_mode);
      check_bit(1'b1, scan_ctl);
      tester.leave();
      check_bit(1'b0, scan_ctl);
    end
    $display("test boundary-scan entry done");
    tester.enter(1'b0, 1'b1);
    d = $random(seed);
    tester.scan(1'b0, 32, d, q, ok);
    check_word(ID_VALUE, q);
    check_bit(1'b1, ok);
    check_bit(1'b0, tdo_oe);
    $display("test identity read done");
    // unknown codes fall back to bypass; 8..E are never assigned
    for (int k = 0; k < 3; k++) begin
      ir_code = (k == 0) ? `JSP_IR_BYPASS : {1'b1, 3'($random(seed))};
      tester.scan(1'b1, 4, {28'h0, ir_code}, q, ok);
      check_word({28'h0, `JSP_IR_CAPTURE}, q);
      d = $random(seed);
      tester.scan(1'b0, 8, d, q, ok);
      check_word({24'h0, d[6:0], 1'b0}, q);
    end
    $display("test bypass done");
    for (int k = 0; k < 4; k++) begin
      ctl = k[1:0];
      tester.scan(1'b1, 4, {28'h0, `JSP_IR_EMU_CTRL}, q, ok);
      tester.scan(1'b0, 2, {30'h0, ctl}, q, ok);
      d = $random(seed);
      emu_a_in = d[0];
      emu_b_in = d[1];
      ea = d[2];
      eb = d[3];
      tester.set_ev(ea, eb, 1'b1);
      tester.wait_clk(4);
      check_bit(ctl[0], dev_a_oe);
      check_bit(ctl[1], dev_b_oe);
      check_bit(ctl[0] ? 1'b0 : ea, emu_a_out);
      check_bit(ctl[1] ? 1'b0 : eb, emu_b_out);
      if (ctl[0]) check_bit(emu_a_in, dev_a);
      if (ctl[1]) check_bit(emu_b_in, dev_b);
    end
    tester.set_ev(1'b0, 1'b0, 1'b0);
    tester.leave();
    check_bit(1'b0, dev_a_oe);
    check_bit(1'b0, dev_b_oe);
    $display("test event pins done");
    print_verdict();
  end
endmodule : tb
